// *** shared/cfg_pkg.sv ***
// Constants for the host-bridge configuration bank of the variant
// without the add-in graphics port.
// Assumes byte offsets inside one function's 256-byte config space.
`default_nettype none

package cfg_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_APERTURE_BASE       = 8'h10;
	localparam logic [7:0] OFF_AGP_MISC_CONFIG     = 8'h51;
	localparam logic [7:0] OFF_GRAPHICS_CONTROL    = 8'h52;
	localparam logic [7:0] OFF_AGP_CAP_HEADER      = 8'ha0;
	localparam logic [7:0] OFF_AGP_STATUS          = 8'ha4;
	localparam logic [7:0] OFF_AGP_COMMAND         = 8'ha8;
	localparam logic [7:0] OFF_AGP_CONTROL         = 8'hb0;
	localparam logic [7:0] OFF_APERTURE_SIZE       = 8'hb4;
	localparam logic [7:0] OFF_APERTURE_TABLE_BASE = 8'hb8;
	localparam logic [7:0] OFF_AGP_MTT_CONTROL     = 8'hbc;
	localparam logic [7:0] OFF_AGP_LOW_PRIO_TIMER  = 8'hbd;
	localparam logic [7:0] OFF_HUB_CONFIG          = 8'hc6;
	localparam logic [7:0] OFF_ERROR_STATUS        = 8'hc8;
	localparam logic [7:0] OFF_ERROR_COMMAND       = 8'hca;
	localparam logic [7:0] OFF_CAPABILITY          = 8'he4;
	localparam logic [7:0] CAP_BYTES               = 8'h05;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int          GFX_OFF_BIT       = 3;
	localparam int          HUB_MODE_BIT      = 3;
	localparam int          CAP_NEXT_LSB      = 8;
	localparam logic [7:0]  GFX_CTL_RESET     = 8'h00;
	localparam logic        GFX_OFF_VALUE     = 1'b0;
	localparam logic [15:0] HUB_RESET         = 16'h0000;
	localparam logic [15:0] ERR_STATUS_RESET  = 16'h0000;
	localparam logic [15:0] ERR_COMMAND_RESET = 16'h0000;
	localparam logic [15:0] ERR_RSVD_MASK     = 16'h001f;
	localparam logic [39:0] CAP_RESET         = 40'h000001060009;
	localparam logic [7:0]  CAP_END_OF_LIST   = 8'h00;

	// ----------------------------------------------------------------
	// Config cycle targets and display ports
	// ----------------------------------------------------------------
	localparam logic [4:0] DEV_HOST_BRIDGE = 5'h00;
	localparam logic [4:0] DEV_GFX_BRIDGE  = 5'h01;
	localparam logic [2:0] FUNC_ZERO       = 3'h0;
	localparam int         DISP_PORTS      = 4;

	// Config answer sequencer
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b01,
		ST_ANSWER = 2'b10
	} cfg_state_e;

endpackage

`default_nettype wire

// *** shared/disp_req_if.sv ***
// Display request and grant bundle between bank top and arbiter.
// Assumes one bit per display port, same clock on both sides.
`default_nettype none

interface disp_req_if #(
	parameter int N = cfg_pkg::DISP_PORTS
);
	logic [N-1:0] req;
	logic [N-1:0] tv;
	logic [N-1:0] digital;
	logic         mirror;
	logic [N-1:0] grant;
	logic         refuse;

	modport arb  (input req, tv, digital, mirror, output grant, refuse);
	modport user (output req, tv, digital, mirror, input grant, refuse);
endinterface

`default_nettype wire

// *** src/strap_capture.sv ***
// Mode strap follower: tracks the pin while reset is held, freezes
// it when reset is released.
// Assumes a synchronous active-low reset and a strap stable at release.
`default_nettype none

module strap_capture (
	// Clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	// Strap pin and captured level
	input  wire logic i_strap,
	output logic      o_mode
);
	import cfg_pkg::*;

	logic held;
	logic next_held;

	// Follow during reset, hold afterwards
	always_comb begin
		next_held = i_rst_n ? held : i_strap;
	end

	// Register the strap copy
	always_ff @(posedge i_mclk) begin
		held <= next_held;
	end

	assign o_mode = held;
endmodule

`default_nettype wire

// *** src/display_arbiter.sv ***
// Single-pipe display port arbiter.
// Assumes requests are levels; results are combinational, the caller
// registers them.
`default_nettype none

module display_arbiter #(
	parameter int N = cfg_pkg::DISP_PORTS
) (
	// Request and grant bundle
	disp_req_if.arb port
);
	import cfg_pkg::*;

	logic [N-1:0] lowest;
	logic [7:0]   req_cnt;
	logic [7:0]   dig_cnt;
	logic         any_tv;
	logic         allow_pair;

	// Count requests and spot the lowest requester
	always_comb begin
		req_cnt = 8'h00;
		dig_cnt = 8'h00;
		for (int i = 0; i < N; i++) begin
			req_cnt = req_cnt + {7'h00, port.req[i]};
			dig_cnt = dig_cnt + {7'h00, port.req[i] & port.digital[i]};
		end
		lowest = port.req & (~port.req + {{(N-1){1'b0}}, 1'b1});
		any_tv = |(port.req & port.tv);
		allow_pair = port.mirror && (req_cnt == 8'h02)
			&& !any_tv
			&& (dig_cnt < 8'h02);
	end

	// One pipe, one timing set: a pair only as a mirror
	always_comb begin
		port.grant  = allow_pair ? port.req : lowest;
		port.refuse = (req_cnt > 8'h01) && !allow_pair;
	end
endmodule

`default_nettype wire

// *** src/cfg_space_variant_deltas.sv ***
// Host-bridge config register bank for the variant without the
// add-in graphics port, plus strap mode and display pipe limits.
// Assumes one config request at a time from the host side, a single
// 100 MHz clock and a synchronous active-low reset.
`default_nettype none

// Behaviour
// - Former aperture and port register offsets are reserved, nothing implemented.
// - Graphics control bit 3 is read-only, 0 means graphics enabled, resets 0.
// - Hub config bit 3 is read-only and mirrors the port mode strap.
// - Strap low reads 0, digital video port mode; high reads 1, graphics only.
// - Mode 0 disables device 1 and forwards its config cycles to hub.
// - Mode 0 fixes capability next-pointer bits 15:8 at 00h.
// - Capability register at E4h is 40-bit read-only, reset 000001060009h.
// - Next-pointer reads 00h, not A0h; capability list ends here.
// - Device 1 implements no registers; its locations are reserved.
// - One pipe may mirror identical content onto two non-TV displays.
// - No mirrored mode while a television output is in use.
// - No mirrored output to two digital displays at once.
// - No concurrent displays with differing data or timings.
// - Strap follows pin during reset and is captured at reset release.
module cfg_space_variant_deltas #(
	parameter int N = cfg_pkg::DISP_PORTS
) (
	// Clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	// Mode strap pin
	input  wire logic        i_port_strap,
	// Config cycle request
	input  wire logic        i_cfg_req,
	input  wire logic        i_cfg_wr,
	input  wire logic [4:0]  i_cfg_dev,
	input  wire logic [2:0]  i_cfg_func,
	input  wire logic [7:0]  i_cfg_addr,
	input  wire logic [3:0]  i_cfg_be,
	input  wire logic [31:0] i_cfg_wdata,
	// Config cycle answer
	output logic             o_cfg_done,
	output logic             o_cfg_fwd,
	output logic [31:0]      o_cfg_rdata,
	// Mode status
	output logic             o_port_mode_bit,
	output logic             o_digital_video_port_on,
	// Display port requests
	input  wire logic [N-1:0] i_disp_req,
	input  wire logic [N-1:0] i_disp_tv,
	input  wire logic [N-1:0] i_disp_digital,
	input  wire logic         i_disp_mirror,
	// Display port grants
	output logic [N-1:0]      o_disp_grant,
	output logic              o_disp_refuse
);
	import cfg_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	cfg_state_e  state;
	cfg_state_e  next_state;
	logic [7:0]  graphics_control_reg;
	logic [7:0]  next_graphics_control_reg;
	logic [15:0] hub_config_reg;
	logic [15:0] next_hub_config_reg;
	logic [15:0] error_command;
	logic [15:0] next_error_command;
	logic        done;
	logic        next_done;
	logic        fwd;
	logic        next_fwd;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic        video_on;
	logic        next_video_on;
	logic [N-1:0] grant;
	logic [N-1:0] next_grant;
	logic        refuse;
	logic        next_refuse;

	logic        port_mode_bit;
	logic        internal_graphics_off;
	logic [7:0]  gfx_ctl_view;
	logic [15:0] hub_view;
	logic [15:0] err_status_view;
	logic [15:0] err_cmd_view;
	logic [39:0] cap_view;
	logic        hit_host;
	logic        hit_gfx;
	logic        gfx_forward;

	disp_req_if #(.N(N)) disp ();

	// ----------------------------------------------------------------
	// Strap capture and arbiter
	// ----------------------------------------------------------------
	strap_capture u_strap (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_strap (i_port_strap),
		.o_mode  (port_mode_bit)
	);

	display_arbiter #(.N(N)) u_arb (
		.port (disp.arb)
	);

	// Display request bundle
	assign disp.req     = i_disp_req;
	assign disp.tv      = i_disp_tv;
	assign disp.digital = i_disp_digital;
	assign disp.mirror  = i_disp_mirror;

	// ----------------------------------------------------------------
	// Read views of the implemented registers
	// ----------------------------------------------------------------
	// Graphics always on in this variant
	assign internal_graphics_off = GFX_OFF_VALUE;

	always_comb begin
		gfx_ctl_view = graphics_control_reg;
		gfx_ctl_view[GFX_OFF_BIT] = internal_graphics_off;
		hub_view = hub_config_reg;
		hub_view[HUB_MODE_BIT] = port_mode_bit;
		// No error source exists here, status stays clear
		err_status_view = ERR_STATUS_RESET;
		err_cmd_view = error_command & ~ERR_RSVD_MASK;
		cap_view = CAP_RESET;
		// No further capability in either mode
		cap_view[CAP_NEXT_LSB +: 8] = CAP_END_OF_LIST;
	end

	// ----------------------------------------------------------------
	// Byte read decode
	// ----------------------------------------------------------------
	// Unlisted and former port offsets read as zero
	function automatic logic [7:0] read_byte(input logic [7:0] a);
		logic [7:0] k;
		k = a - OFF_CAPABILITY;
		read_byte = 8'h00;
		if (a == OFF_GRAPHICS_CONTROL) begin
			read_byte = gfx_ctl_view;
		end else if (a == OFF_HUB_CONFIG) begin
			read_byte = hub_view[7:0];
		end else if (a == OFF_HUB_CONFIG + 8'h01) begin
			read_byte = hub_view[15:8];
		end else if (a == OFF_ERROR_STATUS) begin
			read_byte = err_status_view[7:0];
		end else if (a == OFF_ERROR_STATUS + 8'h01) begin
			read_byte = err_status_view[15:8];
		end else if (a == OFF_ERROR_COMMAND) begin
			read_byte = err_cmd_view[7:0];
		end else if (a == OFF_ERROR_COMMAND + 8'h01) begin
			read_byte = err_cmd_view[15:8];
		end else if (a >= OFF_CAPABILITY && k < CAP_BYTES) begin
			read_byte = cap_view[{k[2:0], 3'b000} +: 8];
		end
	endfunction

	// ----------------------------------------------------------------
	// Target decode
	// ----------------------------------------------------------------
	assign hit_host = (i_cfg_dev == DEV_HOST_BRIDGE) && (i_cfg_func == FUNC_ZERO);
	assign hit_gfx  = (i_cfg_dev == DEV_GFX_BRIDGE);
	// Device 1 traffic goes to the hub while in video port mode
	assign gfx_forward = hit_gfx && !port_mode_bit;

	// ----------------------------------------------------------------
	// Config cycle sequencer
	// ----------------------------------------------------------------
	// Take a request in idle, answer on the following cycle
	always_comb begin
		next_state = state;
		next_done  = 1'b0;
		next_fwd   = 1'b0;
		next_rdata = 32'h00000000;
		unique case (state)
			ST_IDLE: begin
				if (i_cfg_req) begin
					next_state = ST_ANSWER;
					next_done  = 1'b1;
					next_fwd   = gfx_forward;
					if (!i_cfg_wr && hit_host) begin
						for (int l = 0; l < 4; l++) begin
							next_rdata[8*l +: 8] = read_byte({i_cfg_addr[7:2], 2'(l)});
						end
					end
					// Device 1 has no local registers: reads stay zero
				end
			end
			ST_ANSWER: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Register sequencer state and answer
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state <= ST_IDLE;
			done  <= 1'b0;
			fwd   <= 1'b0;
			rdata <= 32'h00000000;
		end else begin
			state <= next_state;
			done  <= next_done;
			fwd   <= next_fwd;
			rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// Byte-lane writes to writable fields; read-only bits masked in view
	always_comb begin
		logic [7:0] a;
		logic [7:0] d;
		a = 8'h00;
		d = 8'h00;
		next_graphics_control_reg = graphics_control_reg;
		next_hub_config_reg       = hub_config_reg;
		next_error_command        = error_command;
		if (state == ST_IDLE && i_cfg_req && i_cfg_wr && hit_host) begin
			for (int l = 0; l < 4; l++) begin
				a = {i_cfg_addr[7:2], 2'(l)};
				d = i_cfg_wdata[8*l +: 8];
				if (i_cfg_be[l]) begin
					if (a == OFF_GRAPHICS_CONTROL) begin
						next_graphics_control_reg = d;
					end else if (a == OFF_HUB_CONFIG) begin
						next_hub_config_reg[7:0] = d;
					end else if (a == OFF_HUB_CONFIG + 8'h01) begin
						next_hub_config_reg[15:8] = d;
					end else if (a == OFF_ERROR_COMMAND) begin
						next_error_command[7:0] = d;
					end else if (a == OFF_ERROR_COMMAND + 8'h01) begin
						next_error_command[15:8] = d;
					end
					// Other lanes, reserved or read-only, are dropped
				end
			end
		end
		// Device 1 writes touch nothing here
	end

	// Register writable fields
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			graphics_control_reg <= GFX_CTL_RESET;
			hub_config_reg       <= HUB_RESET;
			error_command        <= ERR_COMMAND_RESET;
		end else begin
			graphics_control_reg <= next_graphics_control_reg;
			hub_config_reg       <= next_hub_config_reg;
			error_command        <= next_error_command;
		end
	end

	// ----------------------------------------------------------------
	// Mode and display outputs
	// ----------------------------------------------------------------
	// Video port runs while the strap chose mode 0
	always_comb begin
		next_video_on = !port_mode_bit;
		next_grant    = disp.grant;
		next_refuse   = disp.refuse;
	end

	// Register mode and grant outputs
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			video_on <= 1'b0;
			grant    <= '0;
			refuse   <= 1'b0;
		end else begin
			video_on <= next_video_on;
			grant    <= next_grant;
			refuse   <= next_refuse;
		end
	end

	// ----------------------------------------------------------------
	// Output ports
	// ----------------------------------------------------------------
	assign o_cfg_done              = done;
	assign o_cfg_fwd               = fwd;
	assign o_cfg_rdata             = rdata;
	assign o_port_mode_bit         = port_mode_bit;
	assign o_digital_video_port_on = video_on;
	assign o_disp_grant            = grant;
	assign o_disp_refuse           = refuse;
endmodule

`default_nettype wire

// *** verification/cfg_asserts.sv ***
// Concurrent checks on the config bank top ports, bound to the top.
// Assumes one clock and the synchronous active-low reset.
`default_nettype none

module cfg_asserts #(
	parameter int N = 4
) (
	// Clock and reset
	input wire logic         i_mclk,
	input wire logic         i_rst_n,
	// Config cycles
	input wire logic         i_cfg_req,
	input wire logic         i_cfg_wr,
	input wire logic [4:0]   i_cfg_dev,
	input wire logic [2:0]   i_cfg_func,
	input wire logic [7:0]   i_cfg_addr,
	input wire logic         o_cfg_done,
	input wire logic         o_cfg_fwd,
	input wire logic [31:0]  o_cfg_rdata,
	input wire logic         o_port_mode_bit,
	input wire logic         o_digital_video_port_on,
	// Display ports
	input wire logic [N-1:0] i_disp_req,
	input wire logic [N-1:0] i_disp_tv,
	input wire logic [N-1:0] i_disp_digital,
	input wire logic         i_disp_mirror,
	input wire logic [N-1:0] o_disp_grant,
	input wire logic         o_disp_refuse
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Taken requests
	// ----------------------------------------------------------------
	logic take;
	logic rd0;
	assign take = i_cfg_req && !o_cfg_done;
	assign rd0  = take && !i_cfg_wr && i_cfg_dev == 5'h00 && i_cfg_func == 3'h0;

	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	a_mode_frozen: assert property ($past(i_rst_n) |-> $stable(o_port_mode_bit))
		else $error("mode bit moved after reset release");
	a_video_on: assert property ($past(i_rst_n) |->
		o_digital_video_port_on == !$past(o_port_mode_bit))
		else $error("video port flag not inverse of mode");
	a_fwd_dev1: assert property (take && i_cfg_dev == 5'h01 &&
		!o_port_mode_bit |=> o_cfg_done && o_cfg_fwd)
		else $error("device 1 cycle not forwarded");
	a_no_fwd: assert property (take && (i_cfg_dev != 5'h01 || o_port_mode_bit)
		|=> o_cfg_done && !o_cfg_fwd)
		else $error("cycle forwarded wrongly");
	a_idle_zero: assert property (!o_cfg_done |-> o_cfg_rdata == 32'h0 && !o_cfg_fwd)
		else $error("answer outputs set outside answer");
	a_rsvd_zero: assert property (rd0 && i_cfg_addr[7:4] inside {4'h1, 4'ha, 4'hb}
		|=> o_cfg_rdata == 32'h0)
		else $error("reserved location read nonzero");
	a_cap_value: assert property (rd0 && i_cfg_addr[7:2] == 6'h39
		|=> o_cfg_rdata == 32'h01060009)
		else $error("capability low dword wrong");
	a_gfx_igoff: assert property (rd0 && i_cfg_addr[7:2] == 6'h14 |=> !o_cfg_rdata[19])
		else $error("graphics off bit reads one");
	a_hub_mode: assert property (rd0 && i_cfg_addr[7:2] == 6'h31
		|=> o_cfg_rdata[19] == o_port_mode_bit)
		else $error("hub mode bit not strap");
	a_mirror_ok: assert property (i_disp_mirror && $countones(i_disp_req) == 2 &&
		(i_disp_req & i_disp_tv) == '0 && $countones(i_disp_req & i_disp_digital) < 2
		|=> o_disp_grant == $past(i_disp_req) && !o_disp_refuse)
		else $error("eligible mirror pair not granted");
	a_no_tv_pair: assert property ($countones(o_disp_grant) == 2 |->
		(o_disp_grant & $past(i_disp_tv)) == '0)
		else $error("mirror granted with television");
	a_one_digital: assert property ($countones(o_disp_grant) == 2 |->
		$countones(o_disp_grant & $past(i_disp_digital)) < 2)
		else $error("mirror granted on two digital ports");
	a_single_pipe: assert property ($past(i_rst_n) && $countones($past(i_disp_req)) > 2
		|-> $onehot(o_disp_grant) && o_disp_refuse)
		else $error("more than one timing served");
endmodule

bind cfg_space_variant_deltas cfg_asserts #(.N(N)) chk (
	.i_mclk, .i_rst_n, .i_cfg_req, .i_cfg_wr, .i_cfg_dev, .i_cfg_func, .i_cfg_addr,
	.o_cfg_done, .o_cfg_fwd, .o_cfg_rdata, .o_port_mode_bit, .o_digital_video_port_on,
	.i_disp_req, .i_disp_tv, .i_disp_digital, .i_disp_mirror, .o_disp_grant, .o_disp_refuse
);

`default_nettype wire

// *** verification/cfg_host_model.sv ***
// Host side model issuing config cycles to the bank.
// Assumes the answer one cycle after the taking edge, two-cycle spacing.
`default_nettype none

module cfg_host_model (
	// Clock and answer
	input  wire logic        i_mclk,
	input  wire logic        i_done,
	input  wire logic        i_fwd,
	input  wire logic [31:0] i_rdata,
	// Request
	output logic             o_req,
	output logic             o_wr,
	output logic [4:0]       o_dev,
	output logic [2:0]       o_func,
	output logic [7:0]       o_addr,
	output logic [3:0]       o_be,
	output logic [31:0]      o_wdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus at time zero
	initial begin
		{o_req, o_wr, o_dev, o_func, o_addr, o_be, o_wdata} = '0;
	end

	// One cycle; released lines show the inverse, not the old value
	task automatic xfer(input logic wr, input logic [4:0] dev, input logic [2:0] fn,
		input logic [7:0] ad, input logic [3:0] be, input logic [31:0] wd,
		output logic [31:0] rd, output logic fw, output logic dn);
		@(negedge i_mclk);
		{o_req, o_wr, o_dev, o_func, o_addr, o_be, o_wdata} = {1'b1, wr, dev, fn, ad, be, wd};
		@(negedge i_mclk);
		{o_req, o_wr, o_dev, o_func, o_addr, o_be, o_wdata} = {1'b0, ~wr, ~dev, ~fn, ~ad, ~be, ~wd};
		dn = i_done;
		rd = i_rdata;
		fw = i_fwd;
	endtask
endmodule

`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the config bank, strap mode and display limits.
// Assumes the host model and checker are compiled alongside.
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import cfg_pkg::*;
	localparam int N = DISP_PORTS;

	logic          mclk, rst_n, strap, req, wr, done, fwd, mode, vid, mirror, refuse, smode;
	logic [4:0]    dev;
	logic [2:0]    func;
	logic [7:0]    addr, gfx;
	logic [3:0]    be;
	logic [31:0]   wdata, rdata;
	logic [15:0]   hub, ecmd;
	logic [N-1:0]  dreq, tv, dig, grant;
	int            num_errors, compares;
	logic [7:0]    offs [14] = '{8'h10, 8'h52, 8'ha0, 8'ha4, 8'ha8, 8'hb0, 8'hb4, 8'hb8,
		8'hbd, 8'hc6, 8'hc8, 8'he4, 8'he8, 8'h60};

	cfg_space_variant_deltas #(.N(N)) dut (.i_mclk(mclk), .i_rst_n(rst_n),
		.i_port_strap(strap), .i_cfg_req(req), .i_cfg_wr(wr), .i_cfg_dev(dev),
		.i_cfg_func(func), .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata),
		.o_cfg_done(done), .o_cfg_fwd(fwd), .o_cfg_rdata(rdata), .o_port_mode_bit(mode),
		.o_digital_video_port_on(vid), .i_disp_req(dreq), .i_disp_tv(tv),
		.i_disp_digital(dig), .i_disp_mirror(mirror), .o_disp_grant(grant),
		.o_disp_refuse(refuse));
	cfg_host_model host (.i_mclk(mclk), .i_done(done), .i_fwd(fwd), .i_rdata(rdata),
		.o_req(req), .o_wr(wr), .o_dev(dev), .o_func(func), .o_addr(addr), .o_be(be),
		.o_wdata(wdata));

	// ----------------------------------------------------------------
	// Checking and reference model
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up;
		$display("compares %0d, errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Expected dword of the host bridge bank
	function automatic logic [31:0] model_rd(input logic [7:0] a);
		logic [15:0] h;
		h = (hub & 16'hfff7) | {12'h0, smode, 3'h0};
		case (a[7:2])
			6'h14: return {8'h0, gfx & 8'hf7, 16'h0};
			6'h31: return {h, 16'h0};
			6'h32: return {ecmd & 16'hffe0, 16'h0};
			6'h39: return 32'h01060009;
			default: return 32'h0;
		endcase
	endfunction

	// Byte lane writes to the storage bytes only
	task automatic model_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] w);
		if (a[7:2] == 6'h14 && b[2])
			gfx = w[23:16];
		if (a[7:2] == 6'h31 && b[2])
			hub[7:0] = w[23:16];
		if (a[7:2] == 6'h31 && b[3])
			hub[15:8] = w[31:24];
		if (a[7:2] == 6'h32 && b[2])
			ecmd[7:0] = w[23:16];
		if (a[7:2] == 6'h32 && b[3])
			ecmd[15:8] = w[31:24];
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic do_reset(input logic s);
		rst_n = 1'b0;
		strap = s;
		repeat (16) @(negedge mclk);
		check("mode in reset", 32'(s), 32'(mode));
		rst_n = 1'b1;
		{gfx, hub, ecmd, smode} = {8'h00, 16'h0000, 16'h0000, s};
		@(negedge mclk);
		strap = ~s;
		@(negedge mclk);
		check("mode bit", 32'(s), 32'(mode));
		check("video on", 32'(!s), 32'(vid));
	endtask

	task automatic sweep(input bit do_wr);
		logic [31:0] rd, w;
		logic        fw, dn;
		logic [3:0]  b;
		foreach (offs[i]) begin
			if (do_wr) begin
				w = $urandom;
				b = 4'($urandom);
				host.xfer(1'b1, 5'h00, 3'h0, offs[i], b, w, rd, fw, dn);
				check("write done", 32'h1, 32'(dn));
				model_wr(offs[i], b, w);
			end
			host.xfer(1'b0, 5'h00, 3'h0, offs[i], 4'hf, 32'h0, rd, fw, dn);
			check("read done", 32'h1, 32'(dn));
			check("rdata", model_rd(offs[i]), rd);
			check("read fwd", 32'h0, 32'(fw));
		end
	endtask

	task automatic other_fn(input logic [4:0] d, input logic [2:0] f);
		logic [31:0] rd;
		logic        fw, dn;
		host.xfer(1'b1, d, f, 8'h52, 4'hf, 32'hffffffff, rd, fw, dn);
		check("write fwd", 32'(d == 5'h01 && !smode), 32'(fw));
		host.xfer(1'b0, d, f, 8'h00, 4'hf, 32'h0, rd, fw, dn);
		check("read fwd", 32'(d == 5'h01 && !smode), 32'(fw));
		check("other rdata", 32'h0, rd);
	endtask

	task automatic disp_run(input int n);
		logic [N-1:0] g;
		logic         rf;
		int           c;
		repeat (n) begin
			@(negedge mclk);
			{dreq, tv, dig, mirror} = (3*N+1)'($urandom);
			c = $countones(dreq);
			g = dreq & (~dreq + 1'b1);
			rf = c > 1;
			if (mirror && c == 2 && (dreq & tv) == '0 && $countones(dreq & dig) < 2) begin
				g = dreq;
				rf = 1'b0;
			end
			@(negedge mclk);
			check("grant", 32'(g), 32'(grant));
			check("refuse", 32'(rf), 32'(refuse));
		end
	endtask

	// Clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Main sequence, both strap levels with a reset between
	initial begin
		{rst_n, strap, dreq, tv, dig, mirror, num_errors, compares} = '0;
		void'($urandom(89));
		for (int s = 0; s < 2; s++) begin
			do_reset(s[0]);
			sweep(1'b0);
			sweep(1'b1);
			sweep(1'b1);
			other_fn(5'h01, 3'h0);
			other_fn(5'h01, 3'h2);
			other_fn(5'h00, 3'h1);
			other_fn(5'h03, 3'h0);
			sweep(1'b0);
			disp_run(300);
		end
		wrap_up;
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		wrap_up;
	end
endmodule

`default_nettype wire
